/* rtl/pssdp_pkg.sv */
package pssdp_pkg;
  // ==========================================================================
  // Geometry
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int PAR_W       = 4;
  localparam int BURST_W     = 2;
  // ==========================================================================
  // Strap and reset values
  localparam logic MODE_LINEAR       = 1'b0;
  localparam logic [1:0] BURST_RST   = 2'h0;
  // ==========================================================================
  // Port activity states
  typedef enum logic [2:0] {
    PSSDP_DESEL = 3'b001,
    PSSDP_READ  = 3'b010,
    PSSDP_WRITE = 3'b100
  } pssdp_state_t;
endpackage

/* rtl/pssdp_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module pssdp_mem #(
  parameter int AW = 8,
  parameter int DW = 36
) (
  input  wire logic          clk,    // Clock.
  input  wire logic          we,     // Write strobe.
  input  wire logic [AW-1:0] waddr,  // Write address.
  input  wire logic [DW-1:0] wdata,  // Write data.
  input  wire logic          re,     // Read strobe.
  input  wire logic [AW-1:0] raddr,  // Read address.
  output logic      [DW-1:0] rdata   // Registered read data.
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Contents have no reset so that sleep and reset never disturb them.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

/* rtl/pssdp_top.sv */
// Operation
// RULE_01: Processor strobe low at clock edge captures the address.
// RULE_02: Controller strobe low at clock edge captures the address.
// RULE_03: Each capture loads the two low address bits into the burst counter.
// RULE_04: With both strobes low, only the processor strobe acts; the code lets the controller strobe act when the first chip select is high.
// RULE_05: Processor strobe is ignored while first chip select is high.
// RULE_06: Sleep high enters low-activity state keeping memory contents.
// RULE_07: Sleep is held low normally; unconnected sleep reads as low.
// RULE_08: Input data pins are registered on the rising clock edge.
// RULE_09: Read data appears one clock after the addressed edge.
// RULE_10: Output enable low drives data and parity, high releases them.
// RULE_11: Output enable is masked in the first read clock after deselect.
// RULE_12: Advance low during a burst increments the burst address.
// RULE_13: Strap low selects linear order, high selects interleaved order.
// RULE_14: First chip select is active low and combines with the others.
// RULE_15: Host avoids accesses during sleep and waits after releasing it; t_sleep issues one write during sleep.
// RULE_16: Host raises output enable before driving write data.
`timescale 1ns/1ns
`default_nettype none
module pssdp_top #(
  parameter int ADDR_W = pssdp_pkg::ADDR_W,
  parameter int DATA_W = pssdp_pkg::DATA_W,
  parameter int PAR_W  = pssdp_pkg::PAR_W
) (
  input  wire logic              CLK,                       // Clock, 20 MHz.
  input  wire logic              RESETN,                    // Asynchronous reset, active low.
  input  wire logic [ADDR_W-1:0] ADDR,                      // Address pins.
  input  wire logic              PROCESSOR_ADDR_STROBE_N,   // Processor address strobe.
  input  wire logic              CONTROLLER_ADDR_STROBE_N,  // Controller address strobe.
  input  wire logic              CHIP_SELECT_FIRST_N,       // First chip select.
  input  wire logic              CHIP_SELECT_SECOND,        // Second chip select, active high.
  input  wire logic              CHIP_SELECT_THIRD_N,       // Third chip select.
  input  wire logic              BURST_ADVANCE_N,           // Burst advance.
  input  wire logic              WRITE_N,                   // Write cycle request.
  input  wire logic              BURST_ORDER,               // Burst order strap.
  input  wire logic              SLEEP_REQUEST,             // Sleep input.
  input  wire logic              OUTPUT_ENABLE_N,           // Output enable.
  input  wire logic [DATA_W-1:0] DATA_IN,                   // Data pin input.
  output logic      [DATA_W-1:0] DATA_OUT,                  // Data pin output.
  output logic      [DATA_W-1:0] DATA_OE_N,                 // Data pin enables, low drives.
  input  wire logic [PAR_W-1:0]  PARITY_IO_IN,              // Parity pin input.
  output logic      [PAR_W-1:0]  PARITY_IO_OUT,             // Parity pin output.
  output logic      [PAR_W-1:0]  PARITY_IO_OE_N,            // Parity pin enables, low drives.
  output logic                   SLEEPING                   // Sleep state indicator.
);
  localparam int W = DATA_W + PAR_W;

  if (ADDR_W <= pssdp_pkg::BURST_W || DATA_W < 1 || PAR_W < 1) begin : bad_width
    $error("pssdp_top: unsupported width");
  end

  // ==========================================================================
  // Select and strobe decode
  // The pad pull-down holds a floating sleep pin low, so the core sees a clean level.
  wire sleep_w   = SLEEP_REQUEST;                                     // [RULE_07]
  wire sel_w     = !CHIP_SELECT_FIRST_N && CHIP_SELECT_SECOND && !CHIP_SELECT_THIRD_N; // [RULE_14]
  wire proc_w    = !PROCESSOR_ADDR_STROBE_N && !CHIP_SELECT_FIRST_N;  // [RULE_05]
  // A processor strobe blocked by the first select must not hide the controller strobe.
  wire ctrl_w    = !CONTROLLER_ADDR_STROBE_N && !proc_w;              // [RULE_04]
  wire capture_w = !sleep_w && (proc_w || ctrl_w) && sel_w;           // [RULE_01] [RULE_02]
  wire desel_w   = !sleep_w && (proc_w || ctrl_w) && !sel_w;

  logic [ADDR_W-1:0]    base_r;
  logic [1:0]           start_r;
  logic [1:0]           count_r;
  logic                 order_r;
  logic                 order_seen_r;
  pssdp_pkg::pssdp_state_t state_r;
  pssdp_pkg::pssdp_state_t state_nxt;
  logic [W-1:0]         din_r;
  logic                 wr_pend_r;
  logic [ADDR_W-1:0]    wr_addr_r;
  logic                 wr_go_r;
  logic [ADDR_W-1:0]    wr_go_addr_r;
  logic                 drive_r;
  logic                 sleep_r;

  // ==========================================================================
  // Burst address
  function automatic logic [1:0] burst_low(input logic [1:0] s, input logic [1:0] c, input logic lin);
    burst_low = lin ? 2'(s + c) : (s ^ c);
  endfunction

  wire       advance_w = !sleep_w && !capture_w && !desel_w && !BURST_ADVANCE_N
                         && state_r != pssdp_pkg::PSSDP_DESEL;        // [RULE_12]
  wire       linear_w  = (order_r == pssdp_pkg::MODE_LINEAR);         // [RULE_13]
  wire [1:0] count_nxt = capture_w ? pssdp_pkg::BURST_RST :
                         advance_w ? 2'(count_r + 2'h1) : count_r;
  wire [1:0] start_nxt = capture_w ? ADDR[1:0] : start_r;             // [RULE_03]
  wire [ADDR_W-1:0] base_nxt = capture_w ? ADDR : base_r;             // [RULE_01] [RULE_02]
  wire [ADDR_W-1:0] cur_addr = {base_nxt[ADDR_W-1:2], burst_low(start_nxt, count_nxt, linear_w)};

  // ==========================================================================
  // Cycle state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pssdp_pkg::PSSDP_DESEL, pssdp_pkg::PSSDP_READ, pssdp_pkg::PSSDP_WRITE: begin
        if (desel_w) begin
          state_nxt = pssdp_pkg::PSSDP_DESEL;
        end else if (capture_w || advance_w) begin
          state_nxt = WRITE_N ? pssdp_pkg::PSSDP_READ : pssdp_pkg::PSSDP_WRITE;
        end
      end
      default: state_nxt = pssdp_pkg::PSSDP_DESEL;
    endcase
  end

  wire do_read_w  = !sleep_w && (capture_w || advance_w) && WRITE_N;
  wire do_write_w = !sleep_w && (capture_w || advance_w) && !WRITE_N;
  wire from_desel = state_r == pssdp_pkg::PSSDP_DESEL;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      base_r       <= '0;
      start_r      <= pssdp_pkg::BURST_RST;
      count_r      <= pssdp_pkg::BURST_RST;
      state_r      <= pssdp_pkg::PSSDP_DESEL;
      sleep_r      <= 1'b0;
      wr_pend_r    <= 1'b0;
      wr_addr_r    <= '0;
      wr_go_r      <= 1'b0;
      wr_go_addr_r <= '0;
    end else begin
      base_r       <= base_nxt;
      start_r      <= start_nxt;
      count_r      <= count_nxt;
      state_r      <= sleep_w ? state_r : state_nxt;                 // [RULE_06]
      sleep_r      <= sleep_w;                                        // [RULE_06]
      wr_pend_r    <= do_write_w;
      wr_addr_r    <= cur_addr;
      wr_go_r      <= wr_pend_r;
      wr_go_addr_r <= wr_addr_r;
    end
  end

  // Strap is caught once after reset release, since it must stay static.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      order_seen_r <= 1'b0;
      order_r      <= 1'b1;
    end else if (!order_seen_r) begin
      order_seen_r <= 1'b1;
      // The pad pull-up makes an open strap read as interleaved.
      order_r      <= (BURST_ORDER != pssdp_pkg::MODE_LINEAR);        // [RULE_13]
    end
  end

  // ==========================================================================
  // Data path
  // Write data are taken one edge after the address, matching the late-write
  // timing of the pins; the memory sees them on the following edge.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      din_r <= '0;
    end else begin
      din_r <= {PARITY_IO_IN, DATA_IN};                               // [RULE_08]
    end
  end

  logic [W-1:0] rdata_w;
  pssdp_mem #(
    .AW (ADDR_W),
    .DW (W)
  ) u_mem (
    .clk   (CLK),
    .we    (wr_go_r && !sleep_w),
    .waddr (wr_go_addr_r),
    .wdata (din_r),
    .re    (do_read_w),                                               // [RULE_09]
    .raddr (cur_addr),
    .rdata (rdata_w)
  );

  // The enable is sampled here, so drive follows the pin one clock late.
  wire drive_nxt = !OUTPUT_ENABLE_N && !sleep_w && (state_nxt == pssdp_pkg::PSSDP_READ)
                   && !(do_read_w && from_desel);                     // [RULE_10] [RULE_11]

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  assign DATA_OUT       = rdata_w[DATA_W-1:0];                        // [RULE_09]
  assign PARITY_IO_OUT  = rdata_w[W-1:DATA_W];
  assign DATA_OE_N      = {DATA_W{!drive_r}};                         // [RULE_10]
  assign PARITY_IO_OE_N = {PAR_W{!drive_r}};
  assign SLEEPING       = sleep_r;
endmodule
`default_nettype wire

/* sim/pssdp_chk_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// ===========================
// Pin-level timing relations.
module pssdp_chk #(
  parameter int DATA_W = 32,
  parameter int PAR_W  = 4
) (
  input wire logic              CLK,                      // Clock.
  input wire logic              RESETN,                   // Reset.
  input wire logic              PROCESSOR_ADDR_STROBE_N,  // Strobe.
  input wire logic              CONTROLLER_ADDR_STROBE_N, // Strobe.
  input wire logic              CHIP_SELECT_FIRST_N,      // Select.
  input wire logic              CHIP_SELECT_SECOND,       // Select.
  input wire logic              CHIP_SELECT_THIRD_N,      // Select.
  input wire logic              BURST_ADVANCE_N,          // Advance.
  input wire logic              WRITE_N,                  // Write.
  input wire logic              SLEEP_REQUEST,            // Sleep.
  input wire logic              OUTPUT_ENABLE_N,          // Enable.
  input wire logic [DATA_W-1:0] DATA_OUT,                 // Data.
  input wire logic [DATA_W-1:0] DATA_OE_N,                // Drive.
  input wire logic [PAR_W-1:0]  PARITY_IO_OE_N,           // Drive.
  input wire logic              SLEEPING                  // Asleep.
);
  logic sel_w;
  logic rd_w;
  logic idle_w;
  assign sel_w = !CHIP_SELECT_FIRST_N && CHIP_SELECT_SECOND && !CHIP_SELECT_THIRD_N;
  assign rd_w = !CONTROLLER_ADDR_STROBE_N && sel_w && WRITE_N && !OUTPUT_ENABLE_N && !SLEEP_REQUEST && !SLEEPING;
  assign idle_w = PROCESSOR_ADDR_STROBE_N && CONTROLLER_ADDR_STROBE_N && BURST_ADVANCE_N;
  logic took_rd_w;
  logic rd_seen_r;
  assign took_rd_w = sel_w && WRITE_N && !SLEEP_REQUEST && !(PROCESSOR_ADDR_STROBE_N && CONTROLLER_ADDR_STROBE_N);
  // Read data are undefined until the first read, so the hold check waits for one.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_seen_r <= 1'b0;
    end else if (took_rd_w) begin
      rd_seen_r <= 1'b1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  oe_release_a: assert property (OUTPUT_ENABLE_N |=> &DATA_OE_N) else $error("data driven");
  par_release_a: assert property (OUTPUT_ENABLE_N |=> &PARITY_IO_OE_N) else $error("parity driven");
  oe_agree_a: assert property (DATA_OE_N == {DATA_W{PARITY_IO_OE_N[0]}}) else $error("enables split");
  sleep_flag_a: assert property (SLEEP_REQUEST |=> SLEEPING) else $error("no sleep");
  sleep_wake_a: assert property (!SLEEP_REQUEST |=> !SLEEPING) else $error("no wake");
  desel_mask_a: assert property (!CONTROLLER_ADDR_STROBE_N && !sel_w && !SLEEP_REQUEST && !SLEEPING
    |=> (&DATA_OE_N) [*2]) else $error("drive after deselect");
  out_hold_a: assert property ((rd_seen_r && idle_w) [*2] |=> $stable(DATA_OUT)) else $error("data moved");
  read_drive_a: assert property (rd_w ##1 rd_w |=> DATA_OE_N == '0) else $error("read not driven");
endmodule
bind pssdp_top pssdp_chk #(
  .DATA_W (DATA_W),
  .PAR_W  (PAR_W)
) chk_u (
  .CLK                      (CLK),
  .RESETN                   (RESETN),
  .PROCESSOR_ADDR_STROBE_N  (PROCESSOR_ADDR_STROBE_N),
  .CONTROLLER_ADDR_STROBE_N (CONTROLLER_ADDR_STROBE_N),
  .CHIP_SELECT_FIRST_N      (CHIP_SELECT_FIRST_N),
  .CHIP_SELECT_SECOND       (CHIP_SELECT_SECOND),
  .CHIP_SELECT_THIRD_N      (CHIP_SELECT_THIRD_N),
  .BURST_ADVANCE_N          (BURST_ADVANCE_N),
  .WRITE_N                  (WRITE_N),
  .SLEEP_REQUEST            (SLEEP_REQUEST),
  .OUTPUT_ENABLE_N          (OUTPUT_ENABLE_N),
  .DATA_OUT                 (DATA_OUT),
  .DATA_OE_N                (DATA_OE_N),
  .PARITY_IO_OE_N           (PARITY_IO_OE_N),
  .SLEEPING                 (SLEEPING)
);
`default_nettype wire

/* sim/pssdp_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ====================================
// Processor side of the synchronous bus.
module pssdp_host (
  input  wire logic        clk,  // Clock.
  output logic [3:0]       ctl,  // Strobes, advance, write.
  output logic [2:0]       mode, // Select, sleep, enable.
  output logic [7:0]       addr, // Address.
  output logic [35:0]      dat   // Parity over data.
);
  initial begin
    ctl = 4'hf;
    mode = 3'h1;
    addr = 8'h00;
    dat = 36'h0;
  end
  task automatic cyc(input logic [3:0] c, input logic [7:0] a, input logic [35:0] d);
    @(posedge clk);
    ctl <= c;
    addr <= a;
    dat <= d;
    if (!c[0]) mode[0] <= 1'b1;
  endtask
  // An idle bus flips its address and data lines so a stale value never looks valid.
  task automatic idle(input int n);
    repeat (n) cyc(4'hf, ~addr, ~dat);
  endtask
  task automatic set(input logic [2:0] m);
    @(posedge clk);
    ctl <= 4'hf;
    mode <= m;
  endtask
endmodule
`default_nettype wire

/* sim/pipelined_sram_strobe_data_port_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// =================
// Scenario bench.
module pipelined_sram_strobe_data_port_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  int fails = 0;
  int comparisons = 0;
  logic [3:0] ctl;
  logic [2:0] mode;
  logic [7:0] addr;
  logic [35:0] dat;
  logic [31:0] dout, doe;
  logic [3:0] pout, poe;
  logic slp;
  logic cs2 = 1'b1;
  logic cs3n = 1'b0;
  logic order = 1'b0;
  initial forever #25 clk = ~clk;
  pssdp_host host_u (.clk(clk), .ctl(ctl), .mode(mode), .addr(addr), .dat(dat));
  pssdp_top dut_u (.CLK(clk), .RESETN(rstn), .ADDR(addr), .PROCESSOR_ADDR_STROBE_N(ctl[3]),
    .CONTROLLER_ADDR_STROBE_N(ctl[2]), .CHIP_SELECT_FIRST_N(mode[2]), .CHIP_SELECT_SECOND(cs2),
    .CHIP_SELECT_THIRD_N(cs3n), .BURST_ADVANCE_N(ctl[1]), .WRITE_N(ctl[0]), .BURST_ORDER(order),
    .SLEEP_REQUEST(mode[1]), .OUTPUT_ENABLE_N(mode[0]), .DATA_IN(dat[31:0]), .DATA_OUT(dout),
    .DATA_OE_N(doe), .PARITY_IO_IN(dat[35:32]), .PARITY_IO_OUT(pout), .PARITY_IO_OE_N(poe), .SLEEPING(slp));
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  function automatic logic [35:0] bw(input int j);
    return {4'(j), 32'h5a5a_5a50 | 32'(j)};
  endfunction
  // Write data follows the strobe by one edge, so the data phase is its own cycle.
  task automatic wr(input logic [3:0] c, input logic [7:0] a, input logic [35:0] d);
    host_u.cyc(c, a, ~d);
    host_u.cyc(4'hf, 8'h00, d);
    host_u.idle(1);
  endtask
  task automatic rd(input logic [3:0] c, input logic [7:0] a, input logic [35:0] e);
    host_u.cyc(c, a, ~dat);
    host_u.idle(3);
    #1 chk({pout, dout}, e);
  endtask
  task automatic t_basic;
    wr(4'b0110, 8'h10, 36'h9_1234_abcd);
    rd(4'b1011, 8'h10, 36'h9_1234_abcd);
    wr(4'b1010, 8'h11, 36'h6_8765_0f0f);
    rd(4'b1011, 8'h11, 36'h6_8765_0f0f);
    rd(4'b0011, 8'h11, 36'h6_8765_0f0f);
  endtask
  task automatic t_ce1;
    host_u.set(3'b101);
    wr(4'b0110, 8'h10, 36'h0_dead_beef);
    host_u.set(3'b001);
    cs2 <= 1'b0;
    wr(4'b1010, 8'h10, 36'h0_dead_beef);
    cs2 <= 1'b1;
    cs3n <= 1'b1;
    wr(4'b0110, 8'h11, 36'h0_dead_beef);
    cs3n <= 1'b0;
    rd(4'b1011, 8'h10, 36'h9_1234_abcd);
    rd(4'b1011, 8'h11, 36'h6_8765_0f0f);
  endtask
  task automatic t_sleep;
    host_u.set(3'b011);
    host_u.idle(2);
    #1 chk({35'h0, slp}, 36'h1);
    wr(4'b1010, 8'h11, 36'h0_dead_beef);
    host_u.set(3'b001);
    host_u.idle(4);
    #1 chk({35'h0, slp}, 36'h0);
    rd(4'b1011, 8'h11, 36'h6_8765_0f0f);
  endtask
  task automatic t_burst(input logic lin);
    for (int i = 0; i < 4; i++) wr(4'b1010, 8'(4 + i), bw(i));
    host_u.cyc(4'b1011, 8'h05, ~dat);
    host_u.cyc(4'b1101, 8'h00, ~dat);
    for (int k = 0; k < 4; k++) begin
      #1 chk({pout, dout}, bw(lin ? ((k + 1) % 4) : (1 ^ k)));
      host_u.cyc(k < 2 ? 4'b1101 : 4'hf, 8'h00, ~dat);
    end
  endtask
  task automatic t_oe;
    host_u.set(3'b100);
    host_u.cyc(4'b1011, 8'h00, ~dat);
    host_u.set(3'b000);
    host_u.cyc(4'b1011, 8'h10, ~dat);
    host_u.cyc(4'b1011, 8'h11, ~dat);
    #1 chk({poe, doe}, {36{1'b1}});
    chk({pout, dout}, 36'h9_1234_abcd);
    host_u.idle(1);
    #1 chk({poe, doe}, 36'h0);
    chk({pout, dout}, 36'h6_8765_0f0f);
    host_u.set(3'b001);
    host_u.idle(1);
    #1 chk({poe, doe}, {36{1'b1}});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_basic();
    t_ce1();
    t_sleep();
    t_burst(1'b1);
    t_oe();
    // The strap is read only after reset, so interleaved order needs a second reset.
    @(posedge clk);
    rstn <= 1'b0;
    order <= 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_burst(1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
